// ### pkg/flash_ctl_pkg.sv
// Constants and types for the flash program/erase controller
package flash_ctl_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_STATUS  = 4'h4;
    localparam logic [3:0] OFS_ENABLE  = 4'h8;
    localparam logic [3:0] OFS_CLEAR   = 4'hC;
    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int BIT_START   = 15;
    localparam int BIT_PROG_EN = 14;
    localparam int BIT_SEQERR  = 13;
    localparam int BIT_ERASE   = 6;
    localparam logic [15:0] CONTROL_RESET   = 16'h0000;
    localparam logic [15:0] CONTROL_RW_MASK = 16'h404F;
    // ------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------
    localparam logic [3:0] OP_BULK_ERASE = 4'hF;
    localparam logic [3:0] OP_WORD_PROG  = 4'h3;
    localparam logic [3:0] OP_PAGE_ERASE = 4'h2;
    localparam logic [3:0] OP_ROW_PROG   = 4'h1;
    // ------------------------------------------------------------
    // Event bits: 0 done, 1 sequence error
    // ------------------------------------------------------------
    localparam int NUM_EVENTS = 2;
    localparam int EV_DONE    = 0;
    localparam int EV_ERROR   = 1;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OPER_NONE       = 3'h0,
        OPER_ROW_PROG   = 3'h1,
        OPER_WORD_PROG  = 3'h3,
        OPER_PAGE_ERASE = 3'h2,
        OPER_BULK_ERASE = 3'h6
    } oper_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_DONE = 2'b11
    } seq_state_type;

    typedef struct packed {
        logic     req;
        oper_type oper;
    } array_cmd_type;

    typedef struct packed {
        logic        start;
        logic        prog_en;
        logic        seqerr;
        logic        erase;
        logic [3:0]  opsel;
    } control_type;
endpackage

// ### src/flash_op_decode.sv
// Operation decoder for the flash program/erase controller
`timescale 1ns/100ps
module flash_op_decode (
    input  wire logic                    i_erase,
    input  wire logic [3:0]              i_opsel,
    input  wire logic                    i_serial_prog_mode,
    output flash_ctl_pkg::oper_type      o_oper,
    output logic                         o_legal
);
    always_comb begin
        o_oper  = flash_ctl_pkg::OPER_NONE;
        o_legal = 1'b1;
        case (i_opsel)
            flash_ctl_pkg::OP_BULK_ERASE: begin
                if (i_erase && i_serial_prog_mode) begin
                    o_oper = flash_ctl_pkg::OPER_BULK_ERASE;
                end else if (i_erase) begin
                    o_legal = 1'b0;
                end
            end
            flash_ctl_pkg::OP_PAGE_ERASE: begin
                if (i_erase) begin
                    o_oper = flash_ctl_pkg::OPER_PAGE_ERASE;
                end
            end
            flash_ctl_pkg::OP_WORD_PROG: begin
                if (!i_erase) begin
                    o_oper = flash_ctl_pkg::OPER_WORD_PROG;
                end
            end
            flash_ctl_pkg::OP_ROW_PROG: begin
                if (!i_erase) begin
                    o_oper = flash_ctl_pkg::OPER_ROW_PROG;
                end
            end
            default: begin
                o_legal = 1'b0;
            end
        endcase
    end
endmodule // flash_op_decode

// ### src/flash_program_erase_control.sv
// AXI4-Lite flash program/erase controller with start, enable and error control
`timescale 1ns/100ps
module flash_program_erase_control (
    input  wire logic                        i_clk,
    input  wire logic                        i_reset_n,
    input  wire logic                        i_por_n,
    input  wire logic                        i_serial_prog_mode,
    input  wire logic                        i_array_done,
    input  wire logic [3:0]                  i_s_axi_awaddr,
    input  wire logic                        i_s_axi_awvalid,
    output logic                             o_s_axi_awready,
    input  wire logic [31:0]                 i_s_axi_wdata,
    input  wire logic [3:0]                  i_s_axi_wstrb,
    input  wire logic                        i_s_axi_wvalid,
    output logic                             o_s_axi_wready,
    output logic [1:0]                       o_s_axi_bresp,
    output logic                             o_s_axi_bvalid,
    input  wire logic                        i_s_axi_bready,
    input  wire logic [3:0]                  i_s_axi_araddr,
    input  wire logic                        i_s_axi_arvalid,
    output logic                             o_s_axi_arready,
    output logic [31:0]                      o_s_axi_rdata,
    output logic [1:0]                       o_s_axi_rresp,
    output logic                             o_s_axi_rvalid,
    input  wire logic                        i_s_axi_rready,
    output flash_ctl_pkg::array_cmd_type     o_array_cmd,
    output logic                             o_irq
);
    localparam int NE = flash_ctl_pkg::NUM_EVENTS;

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        flash_ctl_pkg::control_type    ctl;
        flash_ctl_pkg::seq_state_type  state;
        flash_ctl_pkg::array_cmd_type  cmd;
        logic [NE-1:0]                 status;
        logic [NE-1:0]                 enable;
        logic                          irq;
        logic                          awready;
        logic                          wready;
        logic                          arready;
        logic                          aw_held;
        logic [3:0]                    aw_addr;
        logic                          w_held;
        logic [31:0]                   w_data;
        logic [3:0]                    w_strb;
        logic                          bvalid;
        logic [1:0]                    bresp;
        logic                          rvalid;
        logic [31:0]                   rdata;
        logic [1:0]                    rresp;
    } regs_type;

    regs_type state_ff;
    regs_type nxt_state;

    flash_ctl_pkg::oper_type dec_oper;
    logic                    dec_legal;

    flash_op_decode u_decode (
        .i_erase            (state_ff.ctl.erase),
        .i_opsel            (state_ff.ctl.opsel),
        .i_serial_prog_mode (i_serial_prog_mode),
        .o_oper             (dec_oper),
        .o_legal            (dec_legal)
    );

    function automatic logic [15:0] control_word(input flash_ctl_pkg::control_type c);
        logic [15:0] w;
        w = 16'h0000;
        w[flash_ctl_pkg::BIT_START]  = c.start;
        w[flash_ctl_pkg::BIT_PROG_EN] = c.prog_en;
        w[flash_ctl_pkg::BIT_SEQERR] = c.seqerr;
        w[flash_ctl_pkg::BIT_ERASE]  = c.erase;
        w[3:0]                       = c.opsel;
        return w;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    logic          wr_go;
    logic          rd_go;
    logic [15:0]   wval;
    logic          start_req;
    logic [NE-1:0] ev;
    logic [NE-1:0] clr;

    always_comb begin
        nxt_state = state_ff;
        wr_go     = 1'b0;
        rd_go     = 1'b0;
        wval      = 16'h0000;
        start_req = 1'b0;
        ev        = '0;
        clr       = '0;

        // Address and data taken independently
        if (i_s_axi_awvalid && state_ff.awready) begin
            nxt_state.aw_held = 1'b1;
            nxt_state.aw_addr = i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid && state_ff.wready) begin
            nxt_state.w_held = 1'b1;
            nxt_state.w_data = i_s_axi_wdata;
            nxt_state.w_strb = i_s_axi_wstrb;
        end
        if (state_ff.bvalid && i_s_axi_bready) begin
            nxt_state.bvalid = 1'b0;
        end
        if (state_ff.aw_held && state_ff.w_held && !state_ff.bvalid) begin
            wr_go            = 1'b1;
            nxt_state.aw_held = 1'b0;
            nxt_state.w_held  = 1'b0;
            nxt_state.bvalid  = 1'b1;
            nxt_state.bresp   = 2'b00;
        end

        // Register writes
        if (wr_go) begin
            wval = control_word(state_ff.ctl);
            if (state_ff.w_strb[0]) begin
                wval[7:0] = state_ff.w_data[7:0];
            end
            if (state_ff.w_strb[1]) begin
                wval[15:8] = state_ff.w_data[15:8];
            end
            if (state_ff.aw_addr == flash_ctl_pkg::OFS_CONTROL) begin
                nxt_state.ctl.prog_en = wval[flash_ctl_pkg::BIT_PROG_EN];
                nxt_state.ctl.erase = wval[flash_ctl_pkg::BIT_ERASE];
                nxt_state.ctl.opsel = wval[3:0];
                if (wval[flash_ctl_pkg::BIT_SEQERR] == 1'b0) begin
                    nxt_state.ctl.seqerr = 1'b0;
                end
                start_req = wval[flash_ctl_pkg::BIT_START] && state_ff.w_strb[1];
            end else if (state_ff.aw_addr == flash_ctl_pkg::OFS_ENABLE) begin
                nxt_state.enable = state_ff.w_data[NE-1:0];
            end else if (state_ff.aw_addr == flash_ctl_pkg::OFS_CLEAR) begin
                clr = state_ff.w_data[NE-1:0];
            end else if (state_ff.aw_addr != flash_ctl_pkg::OFS_STATUS) begin
                nxt_state.bresp = 2'b10;
            end else begin
                nxt_state.bresp = 2'b10;
            end
        end

        // Sequencer
        case (state_ff.state)
            flash_ctl_pkg::ST_IDLE: begin
                if (start_req) begin
                    if (state_ff.ctl.prog_en && dec_legal && (dec_oper != flash_ctl_pkg::OPER_NONE)) begin
                        nxt_state.ctl.start = 1'b1;
                        nxt_state.ctl.seqerr = 1'b0;
                        nxt_state.cmd.req   = 1'b1;
                        nxt_state.cmd.oper  = dec_oper;
                        nxt_state.state     = flash_ctl_pkg::ST_RUN;
                    end else begin
                        nxt_state.ctl.seqerr = 1'b1;
                        ev[flash_ctl_pkg::EV_ERROR] = 1'b1;
                    end
                end
            end
            flash_ctl_pkg::ST_RUN: begin
                if (start_req) begin
                    nxt_state.ctl.seqerr = 1'b1;
                    ev[flash_ctl_pkg::EV_ERROR] = 1'b1;
                end
                if (i_array_done) begin
                    nxt_state.cmd.req = 1'b0;
                    nxt_state.state   = flash_ctl_pkg::ST_DONE;
                end
            end
            flash_ctl_pkg::ST_DONE: begin
                // Start still shows set here, so a new start is improper
                if (start_req) begin
                    nxt_state.ctl.seqerr = 1'b1;
                    ev[flash_ctl_pkg::EV_ERROR] = 1'b1;
                end
                nxt_state.ctl.start = 1'b0;
                nxt_state.cmd.oper  = flash_ctl_pkg::OPER_NONE;
                ev[flash_ctl_pkg::EV_DONE] = 1'b1;
                nxt_state.state     = flash_ctl_pkg::ST_IDLE;
            end
            default: begin
                nxt_state.state = flash_ctl_pkg::ST_IDLE;
            end
        endcase

        // Sticky status, set beats clear
        nxt_state.status = (state_ff.status & ~clr) | ev;
        nxt_state.irq    = |(nxt_state.status & nxt_state.enable);

        // Reads
        if (state_ff.rvalid && i_s_axi_rready) begin
            nxt_state.rvalid = 1'b0;
        end
        if (i_s_axi_arvalid && state_ff.arready) begin
            rd_go            = 1'b1;
            nxt_state.rvalid = 1'b1;
            nxt_state.rresp  = 2'b00;
            nxt_state.rdata  = 32'h0000_0000;
            if (i_s_axi_araddr == flash_ctl_pkg::OFS_CONTROL) begin
                nxt_state.rdata[15:0] = control_word(state_ff.ctl);
            end else if (i_s_axi_araddr == flash_ctl_pkg::OFS_STATUS) begin
                nxt_state.rdata[NE-1:0] = state_ff.status;
            end else if (i_s_axi_araddr == flash_ctl_pkg::OFS_ENABLE) begin
                nxt_state.rdata[NE-1:0] = state_ff.enable;
            end else if (i_s_axi_araddr == flash_ctl_pkg::OFS_CLEAR) begin
                nxt_state.rdata = 32'h0000_0000;
            end else begin
                nxt_state.rresp = 2'b10;
            end
        end

        // Ready flags registered so every bus output leaves a flop
        nxt_state.awready = !nxt_state.aw_held && !nxt_state.bvalid;
        nxt_state.wready  = !nxt_state.w_held && !nxt_state.bvalid;
        nxt_state.arready = !nxt_state.rvalid;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_por_n) begin
            state_ff <= '0;
        end else if (!i_reset_n) begin
            // Control bits survive non-power-on resets
            state_ff        <= '0;
            state_ff.ctl    <= state_ff.ctl;
            state_ff.state  <= state_ff.state;
            state_ff.cmd    <= state_ff.cmd;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_s_axi_awready = state_ff.awready;
    assign o_s_axi_wready  = state_ff.wready;
    assign o_s_axi_bvalid  = state_ff.bvalid;
    assign o_s_axi_bresp   = state_ff.bresp;
    assign o_s_axi_arready = state_ff.arready;
    assign o_s_axi_rvalid  = state_ff.rvalid;
    assign o_s_axi_rdata   = state_ff.rdata;
    assign o_s_axi_rresp   = state_ff.rresp;
    assign o_array_cmd     = state_ff.cmd;
    assign o_irq           = state_ff.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking chk_cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n || !i_por_n);

    AST_START_NEEDS_ENABLE: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_por_n)
        $rose(state_ff.ctl.start) |-> $past(state_ff.ctl.prog_en))
        else $error("start rose without write enable");

    AST_START_HELD: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_por_n)
        state_ff.ctl.start && !i_array_done && state_ff.state == flash_ctl_pkg::ST_RUN |=> state_ff.ctl.start)
        else $error("start cleared before completion");

    AST_DONE_CLEARS: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_por_n)
        state_ff.state == flash_ctl_pkg::ST_RUN && i_array_done |=> ##1 !state_ff.ctl.start)
        else $error("start not cleared after done");

    AST_REQ_MATCHES: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_por_n)
        state_ff.cmd.req |-> state_ff.ctl.start)
        else $error("request without start");

    AST_ERR_ON_BAD: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_por_n)
        start_req && !state_ff.ctl.prog_en |=> state_ff.ctl.seqerr && state_ff.status[flash_ctl_pkg::EV_ERROR])
        else $error("bad start did not flag error");

    AST_NO_BULK: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_por_n)
        state_ff.cmd.req && state_ff.cmd.oper == flash_ctl_pkg::OPER_BULK_ERASE |-> i_serial_prog_mode || $past(i_serial_prog_mode))
        else $error("bulk erase outside serial mode");

    AST_OPER_KIND: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_por_n)
        $rose(state_ff.cmd.req) |-> (state_ff.cmd.oper[0] == 1'b0) == $past(state_ff.ctl.erase))
        else $error("operation kind differs from erase select");

    AST_READ_ZERO: assert property (@(posedge i_clk) disable iff (!i_reset_n || !i_por_n)
        state_ff.rvalid |-> state_ff.rdata[12:7] == 6'h00 && state_ff.rdata[5:4] == 2'h0)
        else $error("unimplemented bits read non-zero");

    // Sequencer outcomes
    AST_RUN_ON_START: assert property (
        start_req && state_ff.state == flash_ctl_pkg::ST_IDLE && state_ff.ctl.prog_en && dec_legal
        && dec_oper != flash_ctl_pkg::OPER_NONE |=> state_ff.cmd.req && state_ff.ctl.start)
        else $error("legal start did not launch");

    AST_INHIBIT: assert property (
        start_req && state_ff.state == flash_ctl_pkg::ST_IDLE && !state_ff.ctl.prog_en |=> !state_ff.cmd.req)
        else $error("operation ran while inhibited");

    AST_UNIMPL_NO_OP: assert property (
        start_req && state_ff.state == flash_ctl_pkg::ST_IDLE && !dec_legal
        |=> !state_ff.cmd.req && state_ff.ctl.seqerr)
        else $error("unimplemented code was run");

    AST_BUSY_ERR: assert property (
        start_req && state_ff.state != flash_ctl_pkg::ST_IDLE |=> state_ff.ctl.seqerr)
        else $error("start while busy not flagged");

    AST_DONE_EVENT: assert property (
        state_ff.state == flash_ctl_pkg::ST_DONE |=> state_ff.status[flash_ctl_pkg::EV_DONE] && !state_ff.ctl.start)
        else $error("completion not reported");

    AST_STATUS_STICKY: assert property (
        state_ff.status[flash_ctl_pkg::EV_ERROR] && !clr[flash_ctl_pkg::EV_ERROR]
        |=> state_ff.status[flash_ctl_pkg::EV_ERROR])
        else $error("error status lost without clear");

    // Bus and interrupt
    AST_IRQ_LEVEL: assert property (
        state_ff.irq == |(state_ff.status & state_ff.enable))
        else $error("interrupt differs from enabled status");

    AST_BVALID_HOLD: assert property (
        state_ff.bvalid && !i_s_axi_bready |=> state_ff.bvalid)
        else $error("write response dropped early");

    AST_RDATA_HOLD: assert property (
        state_ff.rvalid && !i_s_axi_rready |=> state_ff.rvalid && $stable(state_ff.rdata))
        else $error("read data changed while waiting");

    AST_READY_BLOCKED: assert property (
        state_ff.bvalid |-> !state_ff.awready && !state_ff.wready)
        else $error("write ready during response");
endmodule // flash_program_erase_control

// ### test/flash_array_model.sv
// Behavioural flash array timing that answers each start request after a set delay
`timescale 1ns/100ps
module flash_array_model (
    input  wire logic                         i_clk,
    input  wire logic                         i_por_n,
    input  wire flash_ctl_pkg::array_cmd_type i_cmd,
    input  wire logic [7:0]                   i_delay,
    output logic                              o_done
);
    logic       req_ff  = 1'h0;
    logic       busy_ff = 1'h0;
    logic [7:0] cnt_ff  = 8'h00;

    initial o_done = 1'h0;

    // ------------------------------------------------------------
    // Self-timed run, one done pulse per rising request
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        req_ff <= i_cmd.req;
        o_done <= 1'h0;
        if (!i_por_n) begin
            busy_ff <= 1'h0;
            cnt_ff  <= 8'h00;
        end else if (i_cmd.req && !req_ff) begin
            busy_ff <= 1'h1;
            cnt_ff  <= i_delay;
        end else if (busy_ff) begin
            if (cnt_ff == 8'h00) begin
                busy_ff <= 1'h0;
                o_done  <= 1'h1;
            end else begin
                cnt_ff <= cnt_ff - 8'h01;
            end
        end
    end
endmodule // flash_array_model

// ### test/testbench.sv
// Self-checking testbench for the flash program/erase controller
`timescale 1ns/100ps
module testbench;
    logic                         clk = 1'h0, reset_n = 1'h0, por_n = 1'h0, spm = 1'h0, done;
    logic [3:0]                   awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic                         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic                         awready, wready, bvalid, arready, rvalid, irq;
    logic [31:0]                  wdata = 32'h0000_0000, rdata, rdat, ctl_exp;
    logic [1:0]                   bresp, rresp, rsp;
    logic [7:0]                   delay = 8'h10;
    flash_ctl_pkg::array_cmd_type cmd;
    int                           fails = 0, checks_done = 0, cyc = 0;

    flash_program_erase_control DUT (.i_clk(clk), .i_reset_n(reset_n), .i_por_n(por_n),
        .i_serial_prog_mode(spm), .i_array_done(done), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
        .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_array_cmd(cmd), .o_irq(irq));
    flash_array_model partner (.i_clk(clk), .i_por_n(por_n), .i_cmd(cmd), .i_delay(delay), .o_done(done));

    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            fails = fails + 1;
            results();
        end
    end

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw, w, b;
        @(posedge clk);
        {awaddr, wdata, wstrb} <= {a, d, s};
        {awvalid, wvalid, bready} <= 3'h7;
        {aw, w, b} = 3'h7;
        while (b) begin
            @(posedge clk);
            if (bvalid) begin
                rsp = bresp;
                b = 1'h0;
                bready <= 1'h0;
            end
            if (aw && awready) begin
                aw = 1'h0;
                awvalid <= 1'h0;
            end
            if (w && wready) begin
                w = 1'h0;
                wvalid <= 1'h0;
            end
        end
    endtask
    task automatic axi_rd(input logic [3:0] a);
        logic ar, r;
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        {ar, r} = 2'h3;
        while (r) begin
            @(posedge clk);
            if (rvalid) begin
                rdat = rdata;
                rsp = rresp;
                r = 1'h0;
                rready <= 1'h0;
            end
            if (ar && arready) begin
                ar = 1'h0;
                arvalid <= 1'h0;
            end
        end
    endtask

    // ------------------------------------------------------------
    // Expected decode
    // ------------------------------------------------------------
    function automatic logic ok_op(input logic e, input logic [3:0] op, input logic sp);
        if (e) return (op == flash_ctl_pkg::OP_BULK_ERASE && sp) || op == flash_ctl_pkg::OP_PAGE_ERASE;
        return op == flash_ctl_pkg::OP_WORD_PROG || op == flash_ctl_pkg::OP_ROW_PROG;
    endfunction
    function automatic flash_ctl_pkg::oper_type exp_oper(input logic e, input logic [3:0] op);
        if (!e) return (op == flash_ctl_pkg::OP_ROW_PROG) ? flash_ctl_pkg::OPER_ROW_PROG : flash_ctl_pkg::OPER_WORD_PROG;
        return (op == flash_ctl_pkg::OP_PAGE_ERASE) ? flash_ctl_pkg::OPER_PAGE_ERASE : flash_ctl_pkg::OPER_BULK_ERASE;
    endfunction

    // One start attempt with its full expected outcome
    task automatic run(input logic e, input logic [3:0] op, input logic en, input logic sp);
        logic [31:0] cfg;
        logic        ok;
        int          n;
        cfg = {16'h0000, 1'h0, en, 7'h00, e, 2'h0, op};
        ok = en && ok_op(e, op, sp);
        spm <= sp;
        delay <= 8'(16 + $urandom_range(24));
        axi_wr(flash_ctl_pkg::OFS_CLEAR, 32'h0000_0003, 4'hF);
        axi_wr(flash_ctl_pkg::OFS_CONTROL, cfg, 4'hF);
        axi_wr(flash_ctl_pkg::OFS_CONTROL, cfg | 32'h0000_8000, 4'hF);
        #1;
        chk(cmd.req, ok);
        if (ok) begin
            chk(cmd.oper, exp_oper(e, op));
            axi_wr(flash_ctl_pkg::OFS_CONTROL, cfg, 4'hF);
            axi_rd(flash_ctl_pkg::OFS_CONTROL);
            chk(rdat, cfg | 32'h0000_8000);
            n = 0;
            while (cmd.req && n < 100) begin
                @(posedge clk);
                n = n + 1;
            end
            axi_rd(flash_ctl_pkg::OFS_CONTROL);
            chk(rdat, cfg);
        end else begin
            axi_rd(flash_ctl_pkg::OFS_CONTROL);
            chk(rdat, cfg | 32'h0000_2000);
        end
        ctl_exp = ok ? cfg : cfg | 32'h0000_2000;
        axi_rd(flash_ctl_pkg::OFS_STATUS);
        chk(rdat, ok ? 32'h0000_0001 : 32'h0000_0002);
        chk(irq, 1'h1);
        $display("test done erase=%h op=%h enable=%h serial=%h", e, op, en, sp);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int i;
        void'($urandom(31));
        repeat (20) @(posedge clk);
        reset_n <= 1'h1;
        por_n <= 1'h1;
        axi_rd(flash_ctl_pkg::OFS_CONTROL);
        chk(rdat, 32'h0000_0000);
        chk(rsp, 2'h0);
        axi_rd(4'h2);
        chk(rsp, 2'h2);
        axi_wr(flash_ctl_pkg::OFS_STATUS, 32'h0000_0003, 4'hF);
        chk(rsp, 2'h2);
        axi_wr(flash_ctl_pkg::OFS_ENABLE, 32'h0000_0003, 4'hF);
        for (i = 0; i < 32; i++) run(i[4], i[3:0], 1'h1, 1'h1);
        run(1'h1, flash_ctl_pkg::OP_BULK_ERASE, 1'h1, 1'h0);
        run(1'h0, flash_ctl_pkg::OP_WORD_PROG, 1'h0, 1'h1);
        for (i = 0; i < 40; i++) run(1'($urandom), 4'($urandom), $urandom_range(7) != 0, 1'($urandom));
        axi_wr(flash_ctl_pkg::OFS_ENABLE, 32'h0000_0000, 4'hF);
        axi_rd(flash_ctl_pkg::OFS_STATUS);
        chk(irq, 1'h0);
        axi_wr(flash_ctl_pkg::OFS_CLEAR, 32'h0000_0003, 4'hF);
        axi_wr(flash_ctl_pkg::OFS_ENABLE, 32'h0000_0003, 4'hF);
        axi_rd(flash_ctl_pkg::OFS_STATUS);
        chk(irq, 1'h0);
        $display("test done interrupt mask");
        axi_wr(flash_ctl_pkg::OFS_CONTROL, 32'h0000_FFFF, 4'h1);
        ctl_exp = (ctl_exp & 32'h0000_FF00) | 32'h0000_004F;
        axi_rd(flash_ctl_pkg::OFS_CONTROL);
        chk(rdat, ctl_exp);
        reset_n <= 1'h0;
        repeat (3) @(posedge clk);
        reset_n <= 1'h1;
        axi_rd(flash_ctl_pkg::OFS_CONTROL);
        chk(rdat, ctl_exp);
        axi_rd(flash_ctl_pkg::OFS_ENABLE);
        chk(rdat, 32'h0000_0000);
        por_n <= 1'h0;
        repeat (3) @(posedge clk);
        por_n <= 1'h1;
        axi_rd(flash_ctl_pkg::OFS_CONTROL);
        chk(rdat, 32'h0000_0000);
        $display("test done resets");
        results();
    end
endmodule // testbench
